// *** hdl/breaker_failure_guard.v ***
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`include "breaker_failure_guard_defines.vh"

module breaker_failure_guard #(
    parameter MAG_W = 16,
    parameter TIME_W = 16,
    parameter TICK_CYCLES = `BFG_CLK_MHZ * `BFG_TICK_US
) (
    input wire ref_clk,
    input wire rst,
    // Wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Supervision inputs
    input wire [2:0] phaseStart,
    input wire [MAG_W-1:0] phaseMagA,
    input wire [MAG_W-1:0] phaseMagB,
    input wire [MAG_W-1:0] phaseMagC,
    input wire [MAG_W-1:0] residualMag,
    input wire [2:0] poleClosed,
    input wire blockIn,
    // Commands
    output wire [2:0] backupTrip,
    output wire [2:0] retripTrip,
    output reg irq
);
    localparam TICK_W = $clog2(TICK_CYCLES + 1);
    localparam [TICK_W-1:0] TICK_LAST = TICK_CYCLES - 1;

    // Byte-lane merge for register writes
    function [31:0] laneMerge;
        input [31:0] oldVal;
        input [31:0] newVal;
        input [3:0] sel;
        integer i;
        begin
            laneMerge = oldVal;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    laneMerge[i*8 +: 8] = newVal[i*8 +: 8];
                end
            end
        end
    endfunction

    // Failure present under the selected supervision
    function failureSeen;
        input [1:0] mode;
        input currentHigh;
        input closed;
        begin
            case (mode)
                `BFG_MODE_CURRENT: failureSeen = currentHigh;
                `BFG_MODE_CONTACT: failureSeen = closed;
                `BFG_MODE_BOTH: failureSeen = currentHigh | closed;
                default: failureSeen = 1'b0;
            endcase
        end
    endfunction

    reg [1:0] mode_q;
    reg retripEn_q;
    reg [7:0] phThr_q;
    reg [7:0] nThr_q;
    reg [TIME_W-1:0] backupDly_q;
    reg [TIME_W-1:0] retripDly_q;
    reg [TIME_W-1:0] pulseLen_q;
    reg [2:0] statBackup_q;
    reg [2:0] statRetrip_q;
    reg [2:0] maskBackup_q;
    reg [2:0] maskRetrip_q;
    reg [TICK_W-1:0] tickCnt_q;
    reg tick_q;

    wire [MAG_W-1:0] phaseMag [0:2];
    wire [2:0] fault;
    wire [2:0] active;
    wire [2:0] backupEvent;
    wire [2:0] retripEvent;
    wire disabled = mode_q == `BFG_MODE_OFF;
    wire clearAll = disabled | blockIn;
    wire residualHigh = residualMag >= {{(MAG_W-8){1'b0}}, nThr_q};
    wire wbReq = wb_cyc_i & wb_stb_i;
    wire wbCommit = wbReq & wb_we_i & wb_ack_o;
    wire [31:0] ctrlWord;
    wire [31:0] statusWord;
    wire [31:0] maskWord;
    wire [31:0] stateWord;
    reg [31:0] readMux;
    // Write data merged over the addressed register's current value
    wire [31:0] wrMerged = laneMerge(readMux, wb_dat_i, wb_sel_i);

    assign phaseMag[0] = phaseMagA;
    assign phaseMag[1] = phaseMagB;
    assign phaseMag[2] = phaseMagC;

    // 1 ms tick divider
    always @(posedge ref_clk) begin
        if (rst) begin
            tickCnt_q <= {TICK_W{1'b0}};
            tick_q <= 1'b0;
        end else if (tickCnt_q == TICK_LAST) begin
            tickCnt_q <= {TICK_W{1'b0}};
            tick_q <= 1'b1;
        end else begin
            tickCnt_q <= tickCnt_q + {{(TICK_W-1){1'b0}}, 1'b1};
            tick_q <= 1'b0;
        end
    end

    // Per-phase supervision and timers
    genvar p;
    generate
        for (p = 0; p < 3; p = p + 1) begin : g_phase
            wire currentHigh = (phaseMag[p] >= {{(MAG_W-8){1'b0}}, phThr_q})
                | residualHigh;
            assign fault[p] = failureSeen(mode_q, currentHigh, poleClosed[p]);

            phase_channel #(
                .TIME_W(TIME_W)
            ) u_channel (
                .ref_clk(ref_clk),
                .rst(rst),
                .clear(clearAll),
                .tick(tick_q),
                .startIn(phaseStart[p]),
                .fault(fault[p]),
                .retripEn(retripEn_q),
                .backupDelay(backupDly_q),
                .retripDelay(retripDly_q),
                .pulseLen(pulseLen_q),
                .active_q(active[p]),
                .backupTrip_q(backupTrip[p]),
                .retripTrip_q(retripTrip[p]),
                .backupEvent_q(backupEvent[p]),
                .retripEvent_q(retripEvent[p])
            );
        end
    endgenerate

    // Settings registers
    always @(posedge ref_clk) begin
        if (rst) begin
            mode_q <= `BFG_MODE_RST;
            retripEn_q <= `BFG_RETRIP_EN_RST;
            phThr_q <= `BFG_PH_THR_RST;
            nThr_q <= `BFG_N_THR_RST;
            backupDly_q <= `BFG_BACKUP_DLY_RST;
            retripDly_q <= `BFG_RETRIP_DLY_RST;
            pulseLen_q <= `BFG_PULSE_LEN_RST;
            maskBackup_q <= 3'h0;
            maskRetrip_q <= 3'h0;
        end else if (wbCommit) begin
            case (wb_adr_i)
                `BFG_ADDR_CTRL: begin
                    mode_q <= wrMerged[`BFG_CTRL_MODE_MSB:`BFG_CTRL_MODE_LSB];
                    retripEn_q <= wrMerged[`BFG_CTRL_RETRIP_BIT];
                end
                `BFG_ADDR_PH_THR: begin
                    phThr_q <= wrMerged[7:0];
                end
                `BFG_ADDR_N_THR: begin
                    nThr_q <= wb_sel_i[0] ? wb_dat_i[7:0] : nThr_q;
                end
                `BFG_ADDR_BACKUP_DLY: begin
                    backupDly_q <= wrMerged[TIME_W-1:0];
                end
                `BFG_ADDR_RETRIP_DLY: begin
                    retripDly_q <= wrMerged[TIME_W-1:0];
                end
                `BFG_ADDR_PULSE_LEN: begin
                    pulseLen_q <= wrMerged[TIME_W-1:0];
                end
                `BFG_ADDR_MASK: begin
                    if (wb_sel_i[0]) begin
                        maskBackup_q <= wb_dat_i[`BFG_STAT_BACKUP_LSB +: 3];
                        maskRetrip_q <= wb_dat_i[`BFG_STAT_RETRIP_LSB +: 3];
                    end
                end
                default: begin
                    mode_q <= mode_q;
                end
            endcase
        end
    end

    // Sticky event status, write one to clear; a new event wins over the clear
    wire clearStatus = wbCommit && (wb_adr_i == `BFG_ADDR_STATUS) && wb_sel_i[0];
    wire [2:0] clrBackup = clearStatus ? wb_dat_i[`BFG_STAT_BACKUP_LSB +: 3] : 3'h0;
    wire [2:0] clrRetrip = clearStatus ? wb_dat_i[`BFG_STAT_RETRIP_LSB +: 3] : 3'h0;

    always @(posedge ref_clk) begin
        if (rst) begin
            statBackup_q <= 3'h0;
            statRetrip_q <= 3'h0;
            irq <= 1'b0;
        end else begin
            statBackup_q <= (statBackup_q & ~clrBackup) | backupEvent;
            statRetrip_q <= (statRetrip_q & ~clrRetrip) | retripEvent;
            irq <= |((statBackup_q & ~clrBackup & maskBackup_q)
                | (statRetrip_q & ~clrRetrip & maskRetrip_q)
                | (backupEvent & maskBackup_q)
                | (retripEvent & maskRetrip_q));
        end
    end

    // Read views
    assign ctrlWord = {27'h0000000, retripEn_q, 2'h0, mode_q};
    assign statusWord = {25'h0000000, statRetrip_q, 1'b0, statBackup_q};
    assign maskWord = {25'h0000000, maskRetrip_q, 1'b0, maskBackup_q};
    assign stateWord = {15'h0000, blockIn, 1'b0, fault, 1'b0, retripTrip,
        1'b0, backupTrip, 1'b0, active};

    always @* begin
        case (wb_adr_i)
            `BFG_ADDR_CTRL: readMux = ctrlWord;
            `BFG_ADDR_PH_THR: readMux = {24'h000000, phThr_q};
            `BFG_ADDR_N_THR: readMux = {24'h000000, nThr_q};
            `BFG_ADDR_BACKUP_DLY: readMux = {{(32-TIME_W){1'b0}}, backupDly_q};
            `BFG_ADDR_RETRIP_DLY: readMux = {{(32-TIME_W){1'b0}}, retripDly_q};
            `BFG_ADDR_PULSE_LEN: readMux = {{(32-TIME_W){1'b0}}, pulseLen_q};
            `BFG_ADDR_STATUS: readMux = statusWord;
            `BFG_ADDR_MASK: readMux = maskWord;
            `BFG_ADDR_STATE: readMux = stateWord;
            default: readMux = 32'h00000000;
        endcase
    end

    // Wishbone answer: ack one cycle after the request, dropped the next
    always @(posedge ref_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wbReq & ~wb_ack_o;
            if (wbReq && !wb_ack_o && !wb_we_i) begin
                wb_dat_o <= readMux;
            end
        end
    end
endmodule // breaker_failure_guard

// *** hdl/breaker_failure_guard_defines.vh ***
`ifndef BREAKER_FAILURE_GUARD_DEFINES_VH
`define BREAKER_FAILURE_GUARD_DEFINES_VH

// Register byte offsets
`define BFG_ADDR_CTRL 8'h00
`define BFG_ADDR_PH_THR 8'h04
`define BFG_ADDR_N_THR 8'h08
`define BFG_ADDR_BACKUP_DLY 8'h0c
`define BFG_ADDR_RETRIP_DLY 8'h10
`define BFG_ADDR_PULSE_LEN 8'h14
`define BFG_ADDR_STATUS 8'h18
`define BFG_ADDR_MASK 8'h1c
`define BFG_ADDR_STATE 8'h20

// Control field positions
`define BFG_CTRL_MODE_LSB 0
`define BFG_CTRL_MODE_MSB 1
`define BFG_CTRL_RETRIP_BIT 4

// Operating selections
`define BFG_MODE_OFF 2'h0
`define BFG_MODE_CURRENT 2'h1
`define BFG_MODE_CONTACT 2'h2
`define BFG_MODE_BOTH 2'h3

// Status and mask layout
`define BFG_STAT_BACKUP_LSB 0
`define BFG_STAT_RETRIP_LSB 4

// State register layout
`define BFG_STATE_ACTIVE_LSB 0
`define BFG_STATE_BACKUP_LSB 4
`define BFG_STATE_RETRIP_LSB 8
`define BFG_STATE_FAULT_LSB 12
`define BFG_STATE_BLOCK_BIT 16

// Reset values
`define BFG_MODE_RST 2'h1
`define BFG_RETRIP_EN_RST 1'h0
`define BFG_PH_THR_RST 8'h1e
`define BFG_N_THR_RST 8'h1e
`define BFG_BACKUP_DLY_RST 16'h00c8
`define BFG_RETRIP_DLY_RST 16'h0064
`define BFG_PULSE_LEN_RST 16'h0064

// Timing: tick period in microseconds at the clock rate in MHz
`define BFG_CLK_MHZ 250
`define BFG_TICK_US 1000

`endif

// *** hdl/phase_channel.v ***
module phase_channel #(
    parameter TIME_W = 16
) (
    input wire ref_clk,
    input wire rst,
    input wire clear,
    input wire tick,
    input wire startIn,
    input wire fault,
    input wire retripEn,
    input wire [TIME_W-1:0] backupDelay,
    input wire [TIME_W-1:0] retripDelay,
    input wire [TIME_W-1:0] pulseLen,
    output reg active_q,
    output reg backupTrip_q,
    output reg retripTrip_q,
    output reg backupEvent_q,
    output reg retripEvent_q
);
    reg startPrev_q;
    reg [TIME_W-1:0] bkCnt_q;
    reg [TIME_W-1:0] rtCnt_q;
    reg bkDone_q;
    reg rtDone_q;
    reg [TIME_W-1:0] bkPulse_q;
    reg [TIME_W-1:0] rtPulse_q;
    wire startEdge = startIn & ~startPrev_q;
    wire [TIME_W-1:0] bkNext = bkCnt_q + {{(TIME_W-1){1'b0}}, 1'b1};
    wire [TIME_W-1:0] rtNext = rtCnt_q + {{(TIME_W-1){1'b0}}, 1'b1};
    wire bkFire = active_q & fault & tick & ~bkDone_q & (bkNext >= backupDelay);
    wire rtFire = active_q & fault & tick & retripEn & ~rtDone_q & (rtNext >= retripDelay);
    wire pulseOn = pulseLen != {TIME_W{1'b0}};

    // Edge history follows the pin through a clear, so no false start after it
    always @(posedge ref_clk) begin
        if (rst) begin
            startPrev_q <= 1'b0;
        end else begin
            startPrev_q <= startIn;
        end
    end

    always @(posedge ref_clk) begin
        if (rst || clear) begin
            active_q <= 1'b0;
            bkCnt_q <= {TIME_W{1'b0}};
            rtCnt_q <= {TIME_W{1'b0}};
            bkDone_q <= 1'b0;
            rtDone_q <= 1'b0;
            bkPulse_q <= {TIME_W{1'b0}};
            rtPulse_q <= {TIME_W{1'b0}};
            backupTrip_q <= 1'b0;
            retripTrip_q <= 1'b0;
            backupEvent_q <= 1'b0;
            retripEvent_q <= 1'b0;
        end else begin
            backupEvent_q <= bkFire;
            retripEvent_q <= rtFire;
            if (startEdge) begin
                active_q <= 1'b1;
                bkCnt_q <= {TIME_W{1'b0}};
                rtCnt_q <= {TIME_W{1'b0}};
                bkDone_q <= 1'b0;
                rtDone_q <= 1'b0;
            end else if (active_q && !fault) begin
                active_q <= 1'b0;
            end else if (active_q && tick) begin
                if (!bkDone_q) begin
                    bkCnt_q <= bkNext;
                end
                if (!rtDone_q) begin
                    rtCnt_q <= rtNext;
                end
                if (bkFire) begin
                    bkDone_q <= 1'b1;
                end
                if (rtFire) begin
                    rtDone_q <= 1'b1;
                end
            end
            // Trip pulses count down in ticks
            if (bkFire && pulseOn) begin
                backupTrip_q <= 1'b1;
                bkPulse_q <= pulseLen;
            end else if (tick && backupTrip_q) begin
                bkPulse_q <= bkPulse_q - {{(TIME_W-1){1'b0}}, 1'b1};
                if (bkPulse_q <= {{(TIME_W-1){1'b0}}, 1'b1}) begin
                    backupTrip_q <= 1'b0;
                end
            end
            if (rtFire && pulseOn) begin
                retripTrip_q <= 1'b1;
                rtPulse_q <= pulseLen;
            end else if (tick && retripTrip_q) begin
                rtPulse_q <= rtPulse_q - {{(TIME_W-1){1'b0}}, 1'b1};
                if (rtPulse_q <= {{(TIME_W-1){1'b0}}, 1'b1}) begin
                    retripTrip_q <= 1'b0;
                end
            end
        end
    end
endmodule // phase_channel

// *** test/breaker_failure_guard_checker.sv ***
`include "breaker_failure_guard_defines.vh"
module breaker_failure_guard_checker (
    input wire ref_clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire blockIn,
    input wire [2:0] backupTrip,
    input wire [2:0] retripTrip,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [1:0] mode_q;
    reg retripEn_q;
    reg [7:0] mask_q;
    wire wrDone = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
    // Shadow of the settings, updated at the accepting edge
    always @(posedge ref_clk) begin
        if (rst) begin
            mode_q <= `BFG_MODE_RST;
            retripEn_q <= 1'b0;
            mask_q <= 8'h00;
        end else if (wrDone && wb_adr_i == `BFG_ADDR_CTRL) begin
            mode_q <= wb_dat_i[1:0];
            retripEn_q <= wb_dat_i[4];
        end else if (wrDone && wb_adr_i == `BFG_ADDR_MASK) begin
            mask_q <= wb_dat_i[7:0] & 8'h77;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_reset_quiet: assert property (disable iff (1'b0)
        rst |=> !wb_ack_o && !irq && backupTrip == 3'h0 && retripTrip == 3'h0)
        else $error("outputs active after reset");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    chk_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
        && wb_adr_i > 8'h20 |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    chk_block_clears: assert property (
        blockIn |=> backupTrip == 3'h0 && retripTrip == 3'h0) else $error("trip while blocked");
    chk_off_quiet: assert property (
        mode_q == `BFG_MODE_OFF ##1 mode_q == `BFG_MODE_OFF |=> backupTrip == 3'h0
        && retripTrip == 3'h0) else $error("trip while disabled");
    chk_retrip_gated: assert property (
        (retripTrip & ~$past(retripTrip)) != 3'h0 |-> $past(retripEn_q))
        else $error("repeat trip while not enabled");
    chk_irq_masked: assert property (mask_q == 8'h00 ##1 mask_q == 8'h00 |-> !irq)
        else $error("irq with all masked");
    chk_irq_raise: assert property ($rose(backupTrip[0]) && mask_q[0] |-> ##[1:3] irq)
        else $error("irq late after backup trip");
endmodule // breaker_failure_guard_checker

// *** test/fault_source_model.sv ***
module fault_source_model (
    input wire ref_clk,
    input wire rst,
    input wire [2:0] startReq,
    input wire [15:0] magReq,
    input wire [15:0] resReq,
    input wire [2:0] poleReq,
    input wire [2:0] backupTrip,
    output logic [2:0] phaseStart,
    output logic [15:0] phaseMagA,
    output logic [15:0] phaseMagB,
    output logic [15:0] phaseMagC,
    output logic [15:0] residualMag,
    output logic [2:0] poleClosed
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] breakerOpen_q;
    wire [2:0] live = startReq & ~breakerOpen_q;
    always @(posedge ref_clk) begin
        if (rst) begin
            phaseStart <= 3'h0;
            breakerOpen_q <= 3'h0;
        end else begin
            phaseStart <= startReq;
            // Backup breakers interrupt the phase once tripped
            breakerOpen_q <= (breakerOpen_q | backupTrip) & startReq;
        end
    end
    assign phaseMagA = live[0] ? magReq : 16'h0;
    assign phaseMagB = live[1] ? magReq : 16'h0;
    assign phaseMagC = live[2] ? magReq : 16'h0;
    assign residualMag = (|live) ? resReq : 16'h0;
    assign poleClosed = poleReq & ~breakerOpen_q;
endmodule // fault_source_model

// *** test/breaker_failure_guard_tb.sv ***
`include "breaker_failure_guard_defines.vh"
bind breaker_failure_guard breaker_failure_guard_checker i_chk (.ref_clk(ref_clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .blockIn(blockIn), .backupTrip(backupTrip), .retripTrip(retripTrip), .irq(irq));
module breaker_failure_guard_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 10;
    logic ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, blockIn, irq, retripEn;
    logic [7:0] wb_adr_i, maskV;
    logic [31:0] wb_dat_i, wb_dat_o, rdat;
    logic [3:0] wb_sel_i;
    logic [2:0] phaseStart, poleClosed, backupTrip, retripTrip, startReq, poleReq;
    logic [15:0] phaseMagA, phaseMagB, phaseMagC, residualMag, magReq, resReq, mg, rs;
    logic [7:0] defAdr [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] defVal [6] = '{32'h1, 32'h1e, 32'h1e, 32'hc8, 32'h64, 32'h64};
    int errors, check_count, p;
    breaker_failure_guard #(.TICK_CYCLES(T)) i_dut (.ref_clk(ref_clk), .rst(rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .phaseStart(phaseStart), .phaseMagA(phaseMagA), .phaseMagB(phaseMagB),
        .phaseMagC(phaseMagC), .residualMag(residualMag), .poleClosed(poleClosed),
        .blockIn(blockIn), .backupTrip(backupTrip), .retripTrip(retripTrip), .irq(irq));
    fault_source_model i_src (.ref_clk(ref_clk), .rst(rst), .startReq(startReq),
        .magReq(magReq), .resReq(resReq), .poleReq(poleReq), .backupTrip(backupTrip),
        .phaseStart(phaseStart), .phaseMagA(phaseMagA), .phaseMagB(phaseMagB),
        .phaseMagC(phaseMagC), .residualMag(residualMag), .poleClosed(poleClosed));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (exp !== got) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
        output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
        if (n >= 20) begin
            errors++;
            close_out();
        end
    endtask
    task automatic trial(input logic [1:0] mode, input int ph, input logic [15:0] mag,
        input logic [15:0] res, input logic [2:0] pole, input logic exp);
        int tb, tf, tr;
        logic [2:0] oth;
        logic [31:0] st;
        logic [31:0] es;
        tb = 0;
        tf = 0;
        tr = 0;
        oth = 3'h0;
        wb(1'b1, 8'h00, {27'h0, retripEn, 2'h0, mode}, rdat);
        magReq <= mag;
        resReq <= res;
        poleReq <= pole;
        startReq <= 3'h1 << ph;
        for (int n = 1; n <= 200; n++) begin
            @(posedge ref_clk);
            if (backupTrip[ph] === 1'b1 && tb == 0) tb = n;
            if (backupTrip[ph] === 1'b0 && tb != 0 && tf == 0) tf = n;
            if (retripTrip[ph] === 1'b1 && tr == 0) tr = n;
            oth = oth | (backupTrip & ~(3'h1 << ph));
        end
        startReq <= 3'h0;
        check("backup trip", exp, tb != 0);
        check("other phases", 0, oth);
        if (exp) begin
            check("backup delay", 1, tb >= 4 * T && tb <= 6 * T + 5);
            check("pulse width", 1, tf - tb >= 2 * T - 1 && tf - tb <= 4 * T + 1);
        end
        check("repeat trip", exp & retripEn, tr != 0 && tr <= 4 * T);
        wb(1'b0, 8'h18, 32'h0, st);
        es = ({31'h0, exp} << ph) | ({31'h0, exp & retripEn} << (ph + 4));
        check("status", es, st);
        check("irq", |(es[7:0] & maskV), irq);
        wb(1'b1, 8'h18, 32'h77, rdat);
        wb(1'b0, 8'h18, 32'h0, st);
        check("status cleared", 0, st | irq);
    endtask
    initial begin
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, blockIn, retripEn} = 5'h0;
        {wb_adr_i, wb_dat_i, maskV, startReq, poleReq, magReq, resReq} = '0;
        wb_sel_i = 4'hf;
        void'($urandom(32'h7273));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        foreach (defAdr[i]) begin
            wb(1'b0, defAdr[i], 32'h0, rdat);
            check("reset value", defVal[i], rdat);
        end
        wb(1'b0, 8'h40, 32'h0, rdat);
        check("unmapped read", 0, rdat);
        wb(1'b1, 8'h0c, 32'h5, rdat);
        wb(1'b1, 8'h10, 32'h2, rdat);
        wb(1'b1, 8'h14, 32'h3, rdat);
        trial(`BFG_MODE_CURRENT, 0, 16'd50, 16'd0, 3'h0, 1'b1);
        maskV = 8'h77;
        wb(1'b1, 8'h1c, 32'h77, rdat);
        wb(1'b0, 8'h1c, 32'h0, rdat);
        check("mask", 32'h77, rdat);
        trial(`BFG_MODE_CURRENT, 1, 16'd10, 16'd0, 3'h7, 1'b0);
        trial(`BFG_MODE_CONTACT, 2, 16'd90, 16'd90, 3'h0, 1'b0);
        trial(`BFG_MODE_CONTACT, 2, 16'd0, 16'd0, 3'h7, 1'b1);
        trial(`BFG_MODE_OFF, 0, 16'd90, 16'd90, 3'h7, 1'b0);
        trial(`BFG_MODE_BOTH, 1, 16'd0, 16'd0, 3'h7, 1'b1);
        retripEn = 1'b1;
        trial(`BFG_MODE_CURRENT, 0, 16'd50, 16'd0, 3'h0, 1'b1);
        retripEn = 1'b0;
        blockIn <= 1'b1;
        trial(`BFG_MODE_CURRENT, 0, 16'd90, 16'd0, 3'h7, 1'b0);
        blockIn <= 1'b0;
        trial(`BFG_MODE_CURRENT, 2, 16'd29, 16'd29, 3'h7, 1'b0);
        trial(`BFG_MODE_CURRENT, 2, 16'd30, 16'd0, 3'h0, 1'b1);
        repeat (6) begin
            p = $urandom % 3;
            mg = $urandom % 60;
            rs = $urandom % 40;
            trial(`BFG_MODE_CURRENT, p, mg, rs, 3'h0, mg >= 30 || rs >= 30);
        end
        close_out();
    end
endmodule // breaker_failure_guard_tb
